// *** src/uxb_pkg.sv ***
// Purpose: shared constants and types for the serial transmit/baud block
// Assumes: register indices are word indices; byte address is index times four
// Notes: timing is counted in thirds of an instruction cycle (Tcyc)
`default_nettype none
package uxb_pkg;
   localparam int ADR_W = 18;
   // register indices
   localparam logic [15:0] IDX_RX_CTRL = 16'hfed0;
   localparam logic [15:0] IDX_TX_CTRL = 16'hfed1;
   localparam logic [15:0] IDX_BAUD = 16'hfed2;
   localparam logic [15:0] IDX_TX_HOLD = 16'hfed3;
   localparam logic [15:0] IDX_RX_HOLD = 16'hfed4;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // serial_tx_control fields
   localparam int TXC_RUN = 7;
   localparam int TXC_NINE = 6;
   localparam int TXC_PIN_EN = 5;
   localparam int TXC_PUSH_PULL = 4;
   localparam int TXC_SEVEN = 3;
   localparam int TXC_BIT8 = 2;
   localparam int TXC_EMPTY = 1;
   localparam int TXC_IRQ_EN = 0;
   // serial_rx_control fields
   localparam int RXC_PERIOD_SEL = 7;
   localparam int RXC_RUNNING = 5;
   localparam int RXC_BIT8 = 2;
   // baud period factors, in thirds of Tcyc
   localparam logic [5:0] BAUD_MUL_SHORT = 6'h08;
   localparam logic [5:0] BAUD_MUL_LONG = 6'h20;
   localparam int THIRDS_PER_TCYC = 3;
   // data lengths and frame layout
   localparam logic [3:0] LEN_7 = 4'h7;
   localparam logic [3:0] LEN_8 = 4'h8;
   localparam logic [3:0] LEN_9 = 4'h9;
   localparam logic [3:0] FRAME_EXTRA = 4'h2;
   localparam int FRAME_W = 11;
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} uxb_state_t;
   typedef struct packed {
      logic level;
      logic oe_n;
   } uxb_pin_t;
   typedef struct packed {
      logic done;
      logic [8:0] data;
   } uxb_rx_evt_t;
endpackage : uxb_pkg
`default_nettype wire

// *** src/uxb_uart_tx.sv ***
// Purpose: transmit control, shared baud generator and holding registers of a UART
// Assumes: classic Wishbone slave, one-cycle registered ack; rx shifter lives outside
// Notes: CLK_PER_THIRD sets how many clocks make a third of Tcyc
//
// How it works
// (RQ1) setting tx_run starts a frame; hardware clears it; clearing mid-frame aborts at once
// (RQ2) continuous mode: tx_run auto-clears then re-sets, leaving a one-Tcyc gap
// (RQ3) a control write in the auto-clear cycle cancels the automatic re-set
// (RQ4) nine/seven selects give 9, 8 or 7 data bits; both set is forbidden
// (RQ5) one length serves both directions; software changes it only when idle
// (RQ6) tx_pin_enable drives data onto tx_pin; port_direction bit 0 suppresses it
// (RQ7) idle with pin enabled: pin high for push-pull, released for open-drain
// (RQ8) tx_push_pull_select picks push-pull at one, open-drain at zero
// (RQ9) in nine-bit mode tx_ninth_bit is sent as the ninth data bit
// (RQ10) frame start copies tx_holding to tx_shifter, sets empty flag next cycle
// (RQ11) software clears the empty flag and checks it before reloading tx_holding
// (RQ12) continuous mode: empty flag cleared means tx_run re-sets at frame end
// (RQ13) transmit interrupt request while irq enable and empty flag are both one
// (RQ14) software leaves the control register alone while running unless aborting
// (RQ15) baud counter reinitialises whenever rx_running and tx_run are both zero
// (RQ16) software changes the baud reload only while serial activity is stopped
// (RQ17) transmit and receive share one baud setting and tick
// (RQ18) baud period is (reload+1) times 8/3 or 32/3 Tcyc per period select
// (RQ19) software never programs the baud reload with zero
// (RQ20) ninth shifter bit comes from tx_ninth_bit when the frame starts
// (RQ21) end of reception loads rx_holding and rx_ninth_bit from rx_shifter; the code loads rx_ninth_bit only at nine-bit length
// (RQ22) seven-bit length writes zero into bit 7 of rx_holding
// (RQ23) frames carry 7, 8 or 9 data bits and one stop bit, full duplex
// (RQ24) continuous mode sends two stop bits between frames
// (RQ25) low start bit, data lsb first, high stop bit, one baud period each
`timescale 1ns/1ps
`default_nettype none
module uxb_uart_tx #(
   parameter int CLK_PER_THIRD = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [uxb_pkg::ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic port_dir0_i,
   input wire logic rx_running_i,
   input wire uxb_pkg::uxb_rx_evt_t rx_evt_i,
   output uxb_pkg::uxb_pin_t tx_pin_o,
   output logic baud_tick_o,
   output logic [3:0] data_len_o,
   output logic tx_irq_o
);
   localparam int TCYC_CLK = uxb_pkg::THIRDS_PER_TCYC * CLK_PER_THIRD;
   // last gap count: the run bit stays low for exactly one Tcyc between chained frames
   localparam int GAP_LAST = TCYC_CLK - 1;

   // length decode, shared by both directions; forbidden code falls back to eight
   function automatic logic [3:0] data_len(input logic nine, input logic seven);
      if (nine && !seven) begin
         data_len = uxb_pkg::LEN_9;                     // see (RQ4)
      end else if (!nine && seven) begin
         data_len = uxb_pkg::LEN_7;
      end else begin
         data_len = uxb_pkg::LEN_8;
      end
   endfunction : data_len

   // frame image: start bit at bit 0, data lsb first, ones above
   function automatic logic [uxb_pkg::FRAME_W-1:0] frame_of(input logic [3:0] len,
         input logic [7:0] d, input logic b8);
      logic [uxb_pkg::FRAME_W-1:0] f;
      f = '1;
      f[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < int'(len)) begin
            f[i+1] = d[i];
         end
      end
      if (len == uxb_pkg::LEN_9) begin
         f[9] = b8;
      end
      frame_of = f;
   endfunction : frame_of

   logic [7:0] tx_ctrl;
   logic [7:0] next_tx_ctrl;
   logic [7:0] baud_reload;
   logic [7:0] tx_holding;
   logic [7:0] rx_holding;
   logic period_sel;
   logic rx_ninth_bit;
   uxb_pkg::uxb_state_t state;
   logic [uxb_pkg::FRAME_W-1:0] tx_shifter;
   logic [3:0] bits_left;
   logic extra_stop;
   logic [$clog2(TCYC_CLK+1)-1:0] gap_cnt;
   logic [$clog2(CLK_PER_THIRD+1)-1:0] div_cnt;
   logic [5:0] phase;
   logic [7:0] rel_cnt;

   // bus decode
   wire bus_req = cyc_i && stb_i;
   wire wr_go = bus_req && we_i && sel_i[0] && ack_o;
   wire hit_rxc = adr_i == {uxb_pkg::IDX_RX_CTRL, 2'b00};
   wire hit_txc = adr_i == {uxb_pkg::IDX_TX_CTRL, 2'b00};
   wire hit_baud = adr_i == {uxb_pkg::IDX_BAUD, 2'b00};
   wire hit_txh = adr_i == {uxb_pkg::IDX_TX_HOLD, 2'b00};
   wire hit_rxh = adr_i == {uxb_pkg::IDX_RX_HOLD, 2'b00};
   wire ctrl_wr = wr_go && hit_txc;
   wire [7:0] wbyte = dat_i[7:0];

   // named control fields
   wire tx_run = tx_ctrl[uxb_pkg::TXC_RUN];
   wire tx_buffer_empty = tx_ctrl[uxb_pkg::TXC_EMPTY];
   wire tx_pin_enable = tx_ctrl[uxb_pkg::TXC_PIN_EN];
   wire tx_push_pull_select = tx_ctrl[uxb_pkg::TXC_PUSH_PULL];
   wire [3:0] len = data_len(tx_ctrl[uxb_pkg::TXC_NINE], tx_ctrl[uxb_pkg::TXC_SEVEN]);
   wire [7:0] rx_ctrl = {period_sel, 1'b0, rx_running_i, 2'b00, rx_ninth_bit, 2'b00};

   // read selection; unmapped addresses read zero but are still acknowledged
   wire [7:0] rd_byte = hit_rxc ? rx_ctrl :
                        hit_txc ? tx_ctrl :
                        hit_baud ? baud_reload :
                        hit_txh ? tx_holding :
                        hit_rxh ? rx_holding : 8'h00;

   // frame sequencing events
   wire start_frame = (state == uxb_pkg::ST_IDLE) && tx_run;
   wire last_tick = (state == uxb_pkg::ST_SHIFT) && tx_run && baud_tick_o
                    && (bits_left == 4'h1);
   wire chain = !tx_buffer_empty;                          // see (RQ12)
   wire want_extra = chain && !extra_stop;                 // see (RQ24)
   wire run_clr = last_tick && !want_extra;                // see (RQ1)
   wire gap_done = (state == uxb_pkg::ST_GAP) && (gap_cnt == GAP_LAST[$bits(gap_cnt)-1:0]);
   wire run_set = gap_done;                                // see (RQ2)

   // baud generator control
   wire gen_idle = !tx_run && !rx_running_i;               // see (RQ15)
   wire third_tick = div_cnt == CLK_PER_THIRD[$bits(div_cnt)-1:0] - 1'b1;
   wire [5:0] mul = period_sel ? uxb_pkg::BAUD_MUL_LONG : uxb_pkg::BAUD_MUL_SHORT;
   wire phase_end = phase == mul - 6'h01;

   // pin drive, decided here and registered below
   wire drive_en = tx_pin_enable && !port_dir0_i;          // see (RQ6)
   wire line_bit = (state == uxb_pkg::ST_SHIFT) ? tx_shifter[0] : 1'b1;  // see (RQ7)
   wire next_level = tx_push_pull_select ? line_bit : 1'b0;              // see (RQ8)
   wire next_oe_n = !(drive_en && (tx_push_pull_select || !line_bit));

   assign data_len_o = len;                                // see (RQ5)

   // control register: write first, then hardware; auto-clear beats any write
   always_comb begin
      next_tx_ctrl = tx_ctrl;
      if (ctrl_wr) begin
         next_tx_ctrl = wbyte;
      end
      if (start_frame) begin
         next_tx_ctrl[uxb_pkg::TXC_EMPTY] = 1'b1;          // see (RQ10)
      end
      if (run_clr) begin
         next_tx_ctrl[uxb_pkg::TXC_RUN] = 1'b0;            // see (RQ3)
      end else if (run_set) begin
         next_tx_ctrl[uxb_pkg::TXC_RUN] = 1'b1;            // see (RQ2)
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_ctrl <= uxb_pkg::RST_BYTE;
      end else begin
         tx_ctrl <= next_tx_ctrl;
      end
   end

   // plain storage registers; rx completion wins over a software write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         baud_reload <= uxb_pkg::RST_BYTE;
         tx_holding <= uxb_pkg::RST_BYTE;
         rx_holding <= uxb_pkg::RST_BYTE;
         period_sel <= 1'b0;
         rx_ninth_bit <= 1'b0;
      end else begin
         if (wr_go && hit_baud) begin
            baud_reload <= wbyte;
         end
         if (wr_go && hit_txh) begin
            tx_holding <= wbyte;
         end
         if (wr_go && hit_rxc) begin
            period_sel <= wbyte[uxb_pkg::RXC_PERIOD_SEL];
            rx_ninth_bit <= wbyte[uxb_pkg::RXC_BIT8];
         end
         if (rx_evt_i.done && len == uxb_pkg::LEN_9) begin
            rx_ninth_bit <= rx_evt_i.data[8];              // see (RQ21)
         end
         if (rx_evt_i.done) begin
            rx_holding <= {rx_evt_i.data[7] && len != uxb_pkg::LEN_7,
                           rx_evt_i.data[6:0]};            // see (RQ21) (RQ22)
         end else if (wr_go && hit_rxh) begin
            rx_holding <= wbyte;
         end
      end
   end

   // wishbone answer: ack one cycle after the request, write lands on the ack edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req && !ack_o;
         if (bus_req && !ack_o) begin
            dat_o <= {24'h00_0000, rd_byte};
         end
      end
   end

   // baud generator: (reload+1) x mul thirds of Tcyc, restarted whenever idle
   always_ff @(posedge clk_i) begin
      if (rst_i || gen_idle) begin                         // see (RQ15)
         div_cnt <= '0;
         phase <= 6'h00;
         rel_cnt <= baud_reload;
      end else if (third_tick) begin
         div_cnt <= '0;
         phase <= phase_end ? 6'h00 : phase + 6'h01;       // see (RQ18)
         if (phase_end) begin
            rel_cnt <= (rel_cnt == 8'h00) ? baud_reload : rel_cnt - 8'h01;
         end
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // one tick per baud period, shared with the receiver
   assign baud_tick_o = !gen_idle && third_tick && phase_end && rel_cnt == 8'h00;  // see (RQ17)

   // transmit sequencer; a cleared tx_run ends the frame at once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= uxb_pkg::ST_IDLE;
         tx_shifter <= '1;
         bits_left <= 4'h0;
         extra_stop <= 1'b0;
         gap_cnt <= '0;
      end else begin
         case (state)
            uxb_pkg::ST_IDLE: begin
               if (tx_run) begin
                  tx_shifter <= frame_of(len, tx_holding,
                                         tx_ctrl[uxb_pkg::TXC_BIT8]);  // see (RQ9) (RQ20)
                  bits_left <= len + uxb_pkg::FRAME_EXTRA;            // see (RQ23) (RQ25)
                  extra_stop <= 1'b0;
                  state <= uxb_pkg::ST_SHIFT;
               end
            end
            uxb_pkg::ST_SHIFT: begin
               if (!tx_run) begin
                  state <= uxb_pkg::ST_IDLE;               // see (RQ1)
               end else if (baud_tick_o) begin
                  tx_shifter <= {1'b1, tx_shifter[uxb_pkg::FRAME_W-1:1]};
                  if (bits_left != 4'h1) begin
                     bits_left <= bits_left - 4'h1;
                  end else if (want_extra) begin
                     extra_stop <= 1'b1;                   // see (RQ24)
                  end else if (chain && !ctrl_wr) begin
                     gap_cnt <= '0;
                     state <= uxb_pkg::ST_GAP;             // see (RQ2) (RQ3)
                  end else begin
                     state <= uxb_pkg::ST_IDLE;
                  end
               end
            end
            uxb_pkg::ST_GAP: begin
               gap_cnt <= gap_cnt + 1'b1;
               if (gap_done) begin
                  state <= uxb_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= uxb_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // registered pin and interrupt outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_pin_o <= '{level: 1'b0, oe_n: 1'b1};
         tx_irq_o <= 1'b0;
      end else begin
         tx_pin_o <= '{level: next_level, oe_n: next_oe_n};   // see (RQ6) (RQ8)
         tx_irq_o <= tx_ctrl[uxb_pkg::TXC_IRQ_EN] && tx_buffer_empty;  // see (RQ13)
      end
   end

   // helper for checks: length of the inter-frame gap in clocks
   logic [7:0] gap_seen;
   always_ff @(posedge clk_i) begin
      if (rst_i || state != uxb_pkg::ST_GAP) begin
         gap_seen <= 8'h00;
      end else begin
         gap_seen <= gap_seen + 8'h01;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // abort: run bit dropped while a frame is still on the line
   sequence s_abort;
      state == uxb_pkg::ST_SHIFT && !tx_run;
   endsequence

   // continuous restart: run bit back up, then a fresh frame is shifting
   sequence s_restart;
      tx_run ##1 state == uxb_pkg::ST_SHIFT;
   endsequence

   // last stop bit of a chained frame: one more stop bit has to follow
   sequence s_last_chained;
      last_tick && want_extra;
   endsequence

   chk_abort_to_idle: assert property ( // see (RQ1)
      s_abort |=> state == uxb_pkg::ST_IDLE ##1 (tx_pin_o.level || tx_pin_o.oe_n))
      else $error("abort did not return to idle line");
   // measured by the helper count, so a wrong gap end point is caught
   chk_gap_one_tcyc: assert property ( // see (RQ2)
      run_set |=> tx_run && int'(gap_seen) == TCYC_CLK)
      else $error("continuous gap is not one Tcyc");
   chk_chain_restart: assert property ( // see (RQ12)
      run_set |=> s_restart)
      else $error("chained frame did not start");
   chk_write_blocks_rerun: assert property ( // see (RQ3)
      run_clr && ctrl_wr |=> state == uxb_pkg::ST_IDLE ##1 !tx_run)
      else $error("run re-set after control write");
   chk_len_nine: assert property ( // see (RQ4)
      tx_ctrl[uxb_pkg::TXC_NINE] && !tx_ctrl[uxb_pkg::TXC_SEVEN]
      |-> data_len_o == uxb_pkg::LEN_9)
      else $error("nine-bit length not selected");
   chk_len_seven: assert property ( // see (RQ4)
      !tx_ctrl[uxb_pkg::TXC_NINE] && tx_ctrl[uxb_pkg::TXC_SEVEN]
      |-> data_len_o == uxb_pkg::LEN_7)
      else $error("seven-bit length not selected");
   chk_extra_stop: assert property ( // see (RQ24)
      s_last_chained |=> tx_run && extra_stop && tx_shifter[0])
      else $error("second stop bit missing");
   chk_ninth_loaded: assert property ( // see (RQ9) (RQ20)
      start_frame && len == uxb_pkg::LEN_9
      |=> tx_shifter[uxb_pkg::LEN_9] == $past(tx_ctrl[uxb_pkg::TXC_BIT8]))
      else $error("ninth bit not loaded");
   chk_load_sets_empty: assert property ( // see (RQ10) (RQ25)
      $rose(tx_run) |=> tx_buffer_empty && !tx_shifter[0])
      else $error("frame start did not load shifter");
   chk_pin_idle_high: assert property ( // see (RQ7)
      state == uxb_pkg::ST_IDLE && drive_en && tx_push_pull_select
      |=> tx_pin_o.level && !tx_pin_o.oe_n)
      else $error("idle push-pull pin not high");
   chk_pin_suppressed: assert property ( // see (RQ6)
      !drive_en |=> tx_pin_o.oe_n)
      else $error("pin driven while disabled");
   chk_od_never_high: assert property ( // see (RQ8)
      !tx_push_pull_select |=> tx_pin_o.oe_n || !tx_pin_o.level)
      else $error("open-drain pin driven high");
   chk_irq_follows: assert property ( // see (RQ13)
      tx_ctrl[uxb_pkg::TXC_IRQ_EN] && tx_buffer_empty |=> tx_irq_o)
      else $error("transmit request missing");
   chk_baud_reinit: assert property ( // see (RQ15)
      gen_idle ##1 gen_idle |-> phase == 6'h00 && rel_cnt == $past(baud_reload))
      else $error("baud counter not reinitialised");
   chk_rx_seven_bit: assert property ( // see (RQ22)
      rx_evt_i.done && len == uxb_pkg::LEN_7 |=> !rx_holding[7])
      else $error("bit 7 not zero in seven-bit mode");

endmodule : uxb_uart_tx
`default_nettype wire

// *** verif/uxb_remote_rx.sv ***
// Purpose: remote receiver model listening on the transmit line
// Assumes: the line has a pull-up, so a released pin reads high
// Notes: samples mid-bit; a start bit shorter than half a bit is taken as a glitch
`timescale 1ns/1ps
`default_nettype none
module uxb_remote_rx (
   input wire logic clk_i,
   input wire logic line_i,
   input wire logic [15:0] period_i,
   input wire logic [3:0] len_i,
   output logic frame_o,
   output logic [8:0] data_o
);
   int i;
   // wait for a falling edge, confirm the start bit, then shift in the word
   initial begin
      frame_o = 1'b0;
      data_o = 9'h000;
      forever begin
         @(negedge line_i);
         repeat (period_i / 2) @(posedge clk_i);
         if (line_i === 1'b0) begin
            data_o = 9'h000;
            for (i = 0; i < len_i; i++) begin
               repeat (period_i) @(posedge clk_i);
               data_o[i] = line_i; // lsb first
            end
            repeat (period_i) @(posedge clk_i);
            // only a high stop bit closes a frame
            if (line_i === 1'b1) begin
               frame_o <= 1'b1;
               @(posedge clk_i);
               frame_o <= 1'b0;
            end
         end
      end
   end
endmodule : uxb_remote_rx
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: self-checking bench for the serial transmit and baud block
// Assumes: one third of Tcyc is one clock, so a bit lasts (reload+1)*8 clocks
// Notes: frames are judged by the remote model through a pulled-up line
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [17:0] A_RXC = {uxb_pkg::IDX_RX_CTRL, 2'b00};
   localparam logic [17:0] A_TXC = {uxb_pkg::IDX_TX_CTRL, 2'b00};
   localparam logic [17:0] A_BAUD = {uxb_pkg::IDX_BAUD, 2'b00};
   localparam logic [17:0] A_HOLD = {uxb_pkg::IDX_TX_HOLD, 2'b00};
   localparam logic [17:0] A_RXH = {uxb_pkg::IDX_RX_HOLD, 2'b00};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic we_i = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic port_dir0_i = 1'b0;
   logic rx_running_i = 1'b0;
   logic [17:0] adr_i = 18'h00000;
   logic [31:0] dat_i = 32'h00000000;
   uxb_pkg::uxb_rx_evt_t rx_evt_i = '0;
   logic [31:0] dat_o;
   logic ack_o, baud_tick_o, tx_irq_o, frame, line;
   logic [3:0] data_len_o;
   uxb_pkg::uxb_pin_t tx_pin_o;
   logic [8:0] rx_data, d;
   logic [15:0] period = 16'h0018;
   logic [3:0] len = 4'h8;
   logic [7:0] rd, r;
   logic [8:0] exp_q[$];
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int t_last = 0;
   int gap = 0;
   int i, k;
   // pull-up on the line: a released pin reads high
   assign line = tx_pin_o.oe_n ? 1'b1 : tx_pin_o.level;
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   uxb_uart_tx #(.CLK_PER_THIRD(1)) dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
      .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(4'h1), .cyc_i(cyc_i), .stb_i(stb_i),
      .ack_o(ack_o), .port_dir0_i(port_dir0_i), .rx_running_i(rx_running_i),
      .rx_evt_i(rx_evt_i), .tx_pin_o(tx_pin_o), .baud_tick_o(baud_tick_o),
      .data_len_o(data_len_o), .tx_irq_o(tx_irq_o));
   uxb_remote_rx remote (.clk_i(clk_i), .line_i(line), .period_i(period), .len_i(len),
      .frame_o(frame), .data_o(rx_data));
   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // one classic Wishbone cycle; read data lands in rd
   task automatic wb(input logic w, input logic [17:0] a, input logic [7:0] v);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h000000, v};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic wait_idle();
      do wb(1'b0, A_TXC, 8'h00); while (rd[7] !== 1'b0);
   endtask : wait_idle
   // load holding and control, note the word the far side should see
   task automatic send(input logic [7:0] base, input logic [3:0] n, input logic [8:0] v);
      len = n;
      wb(1'b1, A_HOLD, v[7:0]);
      exp_q.push_back(n == 4'h9 ? v : (n == 4'h8 ? {1'b0, v[7:0]} : {2'b0, v[6:0]}));
      wb(1'b1, A_TXC, base | {1'b0, n == 4'h9, 2'b0, n == 4'h7, v[8], 2'b0});
      check({5'h0, data_len_o}, {5'h0, n});
      wait_idle();
      check({8'h0, rd[1]}, 9'h001);
      check({8'h0, tx_irq_o}, {8'h0, base[0]});
      wb(1'b1, A_TXC, base & 8'h7c); // software clears the flag
   endtask : send
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict
   // each word from the far side is taken against the oldest note
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (frame === 1'b1) begin
         gap <= cyc - t_last;
         t_last <= cyc;
         check(rx_data, exp_q.size() > 0 ? exp_q.pop_front() : 9'hxxx);
      end
   end
   // a hang is cut short well past the few thousand cycles the tests need
   initial begin
      repeat (40000) @(posedge clk_i);
      num_errors++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'he95ee55c));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // reset values; the unmapped place ignores the write and reads zero
      wb(1'b1, 18'h00100, 8'hff);
      for (i = 0; i < 4; i++) begin
         wb(1'b0, i == 3 ? 18'h00100 : A_TXC + 18'(4 * i), 8'h00);
         check({1'b0, rd}, 9'h000);
      end
      r = 8'($urandom_range(3, 1)); // never zero
      wb(1'b1, A_BAUD, r); // changed only while idle
      period <= 16'((r + 1) * 8);
      rx_running_i <= 1'b1;
      // the receiver alone keeps the shared generator ticking
      for (i = 0; i < 2; i++) begin
         wb(1'b1, A_RXC, {i[0], 7'h00});
         while (baud_tick_o !== 1'b1) @(posedge clk_i);
         k = 0;
         do begin
            @(posedge clk_i);
            k++;
         end while (baud_tick_o !== 1'b1);
         check(9'(k), 9'((r + 1) * (i ? 32 : 8)));
      end
      rx_running_i <= 1'b0;
      wb(1'b1, A_RXC, 8'h00);
      k = 0;
      repeat (100) begin
         @(posedge clk_i);
         if (baud_tick_o === 1'b1) k++;
      end
      check(9'(k), 9'h000);
      // every length, push-pull with interrupt, then open-drain masked
      for (i = 0; i < 6; i++) begin
         d = 9'($urandom);
         send(i < 3 ? 8'hb1 : 8'ha0, i % 3 == 0 ? 4'h7 : (i % 3 == 1 ? 4'h8 : 4'h9), d);
      end
      // idle pin per enable, driver type and port direction
      for (i = 0; i < 4; i++) begin
         port_dir0_i <= (i == 3);
         wb(1'b1, A_TXC, i == 1 ? 8'h20 : (i == 2 ? 8'h10 : 8'h30));
         @(posedge clk_i);
         check({8'h0, tx_pin_o.oe_n}, {8'h0, i != 0});
         check({8'h0, line}, 9'h001);
      end
      port_dir0_i <= 1'b0;
      len = 4'h8;
      // abort inside the start bit: pin returns high and no word arrives
      wb(1'b1, A_HOLD, 8'h00);
      wb(1'b1, A_TXC, 8'hb0);
      while (line !== 1'b0) @(posedge clk_i);
      wb(1'b1, A_TXC, 8'h30); // clearing run is the allowed abort
      // the registered pin shows idle two edges after the write lands
      repeat (2) @(posedge clk_i);
      check({8'h0, line}, 9'h001);
      wb(1'b0, A_TXC, 8'h00);
      check({8'h0, rd[7]}, 9'h000);
      wb(1'b1, A_TXC, 8'h30);
      // continuous: the flag cleared mid-frame chains a second word
      send(8'hb0, 4'h8, 9'h000);
      exp_q.delete();
      wb(1'b1, A_HOLD, 8'h5a);
      exp_q.push_back(9'h05a);
      wb(1'b1, A_TXC, 8'hb0);
      do wb(1'b0, A_TXC, 8'h00); while (rd[1] !== 1'b1);
      d = 9'($urandom) & 9'h0ff;
      wb(1'b1, A_HOLD, d[7:0]);
      exp_q.push_back(d);
      wb(1'b1, A_TXC, 8'hb0);
      while (exp_q.size() > 0) @(posedge clk_i);
      @(posedge clk_i); // let the monitor's gap update settle
      check({8'h0, gap >= 11 * period && gap <= 11 * period + 8}, 9'h001);
      wait_idle();
      // received words; bit 7 forced low at seven bits
      for (i = 0; i < 3; i++) begin
         wb(1'b1, A_TXC, i == 0 ? 8'h08 : (i == 1 ? 8'h00 : 8'h40));
         d = 9'($urandom);
         rx_evt_i <= '{1'b1, d};
         @(posedge clk_i);
         rx_evt_i <= '{1'b0, d};
         @(posedge clk_i);
         wb(1'b0, A_RXH, 8'h00);
         check({1'b0, rd}, {1'b0, i == 0 ? 1'b0 : d[7], d[6:0]});
         wb(1'b0, A_RXC, 8'h00);
         if (i == 2) check({8'h0, rd[2]}, {8'h0, d[8]});
      end
      check(9'(exp_q.size()), 9'h000);
      give_verdict();
   end
endmodule : tb
`default_nettype wire
